// ### ebsc_bus_ctrl.sv
// External bus address, select and strobe sequencer.
// Assumes the core issues one request at a time and waits for done.
//
// Operation
// - Drive 16-bit address bus, all bits at once, for every external access.
// - Float all address lines while output-disable input is low.
// - Program select high, low only during off-chip program accesses.
// - Data select high, low only during its off-chip access cycle.
// - I/O select high, low only during external I/O port accesses.
// - Float selects, direction and read strobe while output-disable is low.
// - Ready sampled low extends cycle by one clock, then resampled.
// - Direction line high (read) by default, low only during writes.
// - Read strobe asserted on every external read of any space.
// - Mode register bit 15 chooses read strobe or inverted direction.
// - Bus-cycle strobe high except low marking an external cycle.
// - Data bus floats unless outputting write data (direction low).
`timescale 1ns/10ps
module ebsc_bus_ctrl
    import ebsc_pkg::*;
(
    // ------------------------------------------------------------
    // Clock and reset
    // ------------------------------------------------------------
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    // ------------------------------------------------------------
    // Core request side
    // ------------------------------------------------------------
    input  wire logic                      req_valid_in,
    input  wire ebsc_pkg::ebsc_req_t       req_in,
    output logic                           req_ready_out,
    output logic                           done_out,
    output logic [ebsc_pkg::DATA_W-1:0]    rdata_out,
    // ------------------------------------------------------------
    // Mode register write port
    // ------------------------------------------------------------
    input  wire logic                      mode_we_in,
    input  wire logic [ebsc_pkg::MODE_W-1:0] mode_wdata_in,
    output logic [ebsc_pkg::MODE_W-1:0]    processor_mode_reg_out,
    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    input  wire logic                      out_disable_n_in,
    input  wire logic                      ready_in,
    output logic [ebsc_pkg::ADDR_W-1:0]    ext_addr_bus_out,
    output logic                           ext_addr_bus_oe_out,
    input  wire logic [ebsc_pkg::DATA_W-1:0] ext_data_bus_in,
    output logic [ebsc_pkg::DATA_W-1:0]    ext_data_bus_out,
    output logic                           ext_data_bus_oe_out,
    output ebsc_pkg::ebsc_ctl_t            ctl_out,
    output logic                           ctl_oe_out
);
    import ebsc_pkg::*;

    typedef enum logic [1:0] {
        EBSC_IDLE,
        EBSC_ACCESS
    } ebsc_state_t;

    ebsc_state_t          state;
    ebsc_req_t            cur;
    logic [MODE_W-1:0]    processor_mode_reg;
    logic                 read_pin_function_sel;
    logic                 ready_sync;
    logic                 off_sync_n;
    logic                 finish;
    logic [1:0]           lat;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ebsc_sync2 #(.RESET_VAL(1'b1)) u_sync_ready (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (ready_in),
        .q_out  (ready_sync)
    );

    ebsc_sync2 #(.RESET_VAL(1'b1)) u_sync_off (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (out_disable_n_in),
        .q_out  (off_sync_n)
    );

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            processor_mode_reg <= MODE_RESET;
        end else if (mode_we_in) begin
            processor_mode_reg <= mode_wdata_in;
        end
    end

    assign read_pin_function_sel  = processor_mode_reg[RD_FUNC_BIT];
    assign processor_mode_reg_out = processor_mode_reg;

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    // Ready only counts once the strobe has reached the pin and come back
    // through the synchroniser; an earlier sample is stale
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lat <= 2'h0;
        end else if (state != EBSC_ACCESS) begin
            lat <= 2'h0;
        end else if (lat != RDY_LAT) begin
            lat <= lat + 2'h1;
        end
    end

    assign finish        = (state == EBSC_ACCESS) && (lat == RDY_LAT) && ready_sync;
    assign req_ready_out = (state == EBSC_IDLE);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= EBSC_IDLE;
        end else begin
            unique case (state)
                EBSC_IDLE: begin
                    if (req_valid_in) begin
                        state <= EBSC_ACCESS;
                    end
                end
                EBSC_ACCESS: begin
                    // Stay one more clock per low ready sample
                    if (finish) begin
                        state <= EBSC_IDLE;
                    end
                end
                default: begin
                    state <= EBSC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur <= '{space: EBSC_SPACE_PROG, write: 1'b0,
                     addr: ADDR_RESET, wdata: DATA_RESET};
        end else if (req_ready_out && req_valid_in) begin
            cur <= req_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_out  <= 1'b0;
            rdata_out <= DATA_RESET;
        end else begin
            done_out <= finish;
            if (finish && !cur.write) begin
                rdata_out <= ext_data_bus_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, all from flops
    // ------------------------------------------------------------
    ebsc_ctl_t next_ctl;
    logic      active;

    assign active = (state == EBSC_ACCESS);

    always_comb begin
        next_ctl = '{default: 1'b1};
        if (active) begin
            // One-hot select by space
            unique case (cur.space)
                EBSC_SPACE_PROG: next_ctl.prog_space_sel_n = 1'b0;
                EBSC_SPACE_DATA: next_ctl.data_space_sel_n = 1'b0;
                EBSC_SPACE_IO:   next_ctl.io_space_sel_n   = 1'b0;
                default:         next_ctl.prog_space_sel_n = 1'b1;
            endcase
            next_ctl.bus_cycle_strobe_n = 1'b0;
            next_ctl.rd_wr_n            = !cur.write;
        end
        // Inverted direction mode follows direction, not cycle activity
        if (read_pin_function_sel) begin
            next_ctl.read_sel_n = !next_ctl.rd_wr_n;
        end else begin
            next_ctl.read_sel_n = !(active && !cur.write);
        end
    end

    // Registered outputs lag the state by one clock; the strobes are
    // computed from the state so they stay aligned with each other.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctl_out          <= '{default: 1'b1};
            ext_addr_bus_out <= ADDR_RESET;
        end else begin
            ctl_out          <= next_ctl;
            ext_addr_bus_out <= cur.addr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_data_bus_out <= DATA_RESET;
        end else begin
            ext_data_bus_out <= cur.wdata;
        end
    end

    // ------------------------------------------------------------
    // Output enables
    // ------------------------------------------------------------
    assign ext_addr_bus_oe_out = off_sync_n;
    assign ctl_oe_out          = off_sync_n;
    // Data drives only while the direction pin shows write
    assign ext_data_bus_oe_out = off_sync_n && !ctl_out.rd_wr_n;
endmodule : ebsc_bus_ctrl

// ### ebsc_pkg.sv
// Package for the external bus strobe controller.
// Assumes a single core clock; data bus resolved by the testbench from its enable.
package ebsc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W        = 16;
    localparam int DATA_W        = 16;
    localparam int MODE_W        = 16;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int RD_FUNC_BIT   = 15;
    // Clocks from taking a request until a synchronised ready is current
    localparam logic [1:0] RDY_LAT = 2'h3;
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    typedef enum logic [1:0] {
        EBSC_SPACE_PROG,
        EBSC_SPACE_DATA,
        EBSC_SPACE_IO
    } ebsc_space_t;

    // Core request carrier
    typedef struct packed {
        ebsc_space_t         space;
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } ebsc_req_t;

    // Pin-side strobe group
    typedef struct packed {
        logic prog_space_sel_n;
        logic data_space_sel_n;
        logic io_space_sel_n;
        logic rd_wr_n;
        logic read_sel_n;
        logic bus_cycle_strobe_n;
    } ebsc_ctl_t;
endpackage : ebsc_pkg

// ### ebsc_sync2.sv
// Two-flop synchroniser for one pin input.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/10ps
module ebsc_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Data
    input  wire logic d_in,
    output logic      q_out
);
    logic meta;

    // First stage read only by the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta  <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : ebsc_sync2

// ### ebsc_ext_mem.sv
// External memory model for the bus strobe controller.
// Assumes pins come straight from the controller; data bus resolved outside.
`timescale 1ns/10ps
module ebsc_ext_mem
    import ebsc_pkg::*;
(
    // Pins and settings
    input  wire logic                    clk_in,
    input  wire logic [3:0]              wait_in,
    input  wire ebsc_pkg::ebsc_ctl_t     ctl_in,
    input  wire logic [ebsc_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [ebsc_pkg::DATA_W-1:0] data_in,
    // Answers
    output logic                         ready_out,
    output logic [ebsc_pkg::DATA_W-1:0]  rdata_out,
    output logic [ebsc_pkg::DATA_W-1:0]  wr_seen_out
);
    logic [3:0]        cnt;
    logic [DATA_W-1:0] last;
    wire sel = !ctl_in.bus_cycle_strobe_n;
    always_ff @(posedge clk_in) begin
        cnt <= sel ? cnt - (cnt != 4'h0) : wait_in;
        if (sel && !ctl_in.rd_wr_n) wr_seen_out <= data_in;
        last <= rdata_out;
    end
    // Idle keeps ready high; stall counts down once selected
    assign ready_out = !sel || cnt == 4'h0;
    // Released bus shows the inverse of the last value, not a stale copy
    assign rdata_out = (sel && ctl_in.rd_wr_n) ? addr_in ^ 16'hA5A5 : ~last;
endmodule : ebsc_ext_mem

// ### ebsc_chk.sv
// Checker for the bus strobe controller.
// Bound to ebsc_bus_ctrl; sees its ports only.
`timescale 1ns/10ps
module ebsc_chk
    import ebsc_pkg::*;
(
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire logic                    req_valid_in,
    input wire logic                    req_ready_out,
    input wire logic                    done_out,
    input wire logic                    mode_we_in,
    input wire logic [ebsc_pkg::MODE_W-1:0] mode_wdata_in,
    input wire logic [ebsc_pkg::MODE_W-1:0] processor_mode_reg_out,
    input wire logic                    out_disable_n_in,
    input wire logic                    ready_in,
    input wire logic                    ext_addr_bus_oe_out,
    input wire logic                    ext_data_bus_oe_out,
    input wire ebsc_pkg::ebsc_ctl_t     ctl_out,
    input wire logic                    ctl_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire [2:0] sel_n = {ctl_out.prog_space_sel_n, ctl_out.data_space_sel_n,
                        ctl_out.io_space_sel_n};
    wire m = processor_mode_reg_out[15];
    a_one_select: assert property ($countones(~sel_n) <= 1)
        else $error("two space selects low");
    a_addr_float: assert property (!out_disable_n_in [*4] |-> !ext_addr_bus_oe_out)
        else $error("address driven while disabled");
    a_ctl_float: assert property (!out_disable_n_in [*4] |-> !ctl_oe_out)
        else $error("controls driven while disabled");
    a_data_dir: assert property (ctl_out.rd_wr_n && $past(ctl_out.rd_wr_n)
        |-> !ext_data_bus_oe_out)
        else $error("data driven during read");
    a_inv_dir: assert property (m [*3] |-> ctl_out.read_sel_n != ctl_out.rd_wr_n)
        else $error("read pin not inverted direction");
    a_read_only: assert property (!m [*3] ##0 !ctl_out.read_sel_n |-> ctl_out.rd_wr_n)
        else $error("read strobe on write");
    a_strobe_sel: assert property (sel_n != 3'h7 |-> !ctl_out.bus_cycle_strobe_n)
        else $error("select without strobe");
    a_done_bound: assert property (req_valid_in && req_ready_out |-> ##[2:40] done_out)
        else $error("no completion");
    a_wait_ready: assert property (!ready_in [*6] |-> !done_out)
        else $error("done while not ready");
    a_mode_write: assert property (mode_we_in |=> processor_mode_reg_out
        == $past(mode_wdata_in))
        else $error("mode write lost");
    a_idle_high: assert property (req_ready_out [*3] |-> sel_n == 3'h7)
        else $error("select low while idle");
endmodule : ebsc_chk
bind ebsc_bus_ctrl ebsc_chk ebsc_chk_i (.*);

// ### tb_ebsc_bus_ctrl.sv
// Testbench for the bus strobe controller.
// External memory model answers; inputs change at falling edges.
`timescale 1ns/10ps
module tb_ebsc_bus_ctrl;
    import ebsc_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, mode_we_in = 1'b0;
    logic out_disable_n_in = 1'b1, rdy, req_ready_out, done_out, inv = 1'b0;
    logic addr_oe, dbus_oe, ctl_oe;
    logic [3:0] wait_cyc = 4'h0;
    logic [15:0] mode_wdata_in = 16'h0000, rdata_out, mode_reg, addr, cap_addr;
    logic [15:0] dbus_out, mem_rdata, wr_seen;
    ebsc_req_t req_in = '0;
    ebsc_ctl_t ctl, cap_ctl;
    int n_errors = 0, checks_done = 0, d0, d3;
    wire [15:0] dbus = dbus_oe ? dbus_out : mem_rdata;
    always #2 clk_in = ~clk_in;
    ebsc_bus_ctrl ebsc_bus_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .done_out(done_out), .rdata_out(rdata_out), .mode_we_in(mode_we_in),
        .mode_wdata_in(mode_wdata_in), .processor_mode_reg_out(mode_reg),
        .out_disable_n_in(out_disable_n_in), .ready_in(rdy), .ext_addr_bus_out(addr),
        .ext_addr_bus_oe_out(addr_oe), .ext_data_bus_in(dbus),
        .ext_data_bus_out(dbus_out), .ext_data_bus_oe_out(dbus_oe),
        .ctl_out(ctl), .ctl_oe_out(ctl_oe));
    ebsc_ext_mem ebsc_ext_mem_i (.clk_in(clk_in), .wait_in(wait_cyc), .ctl_in(ctl),
        .addr_in(addr), .data_in(dbus), .ready_out(rdy), .rdata_out(mem_rdata),
        .wr_seen_out(wr_seen));
    always @(posedge clk_in) if (!ctl.bus_cycle_strobe_n) begin
        cap_ctl <= ctl;
        cap_addr <= addr;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task access(input int sp, input logic wr, input logic [15:0] a, output int n);
        n = 0;
        while (!req_ready_out) @(negedge clk_in);
        req_in = '{ebsc_space_t'(sp), wr, a, a ^ 16'h3C3C};
        req_valid_in = 1'b1;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        while (!done_out && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        chk(cap_addr, a);
        chk(3'h7 & ~{cap_ctl.prog_space_sel_n, cap_ctl.data_space_sel_n,
            cap_ctl.io_space_sel_n}, 3'h4 >> sp);
        chk(cap_ctl.rd_wr_n, !wr);
        chk(cap_ctl.read_sel_n, wr);
        chk(wr ? wr_seen : rdata_out, wr ? a ^ 16'h3C3C : a ^ 16'hA5A5);
        @(negedge clk_in);
        chk({ctl.rd_wr_n, ctl.bus_cycle_strobe_n}, 2'h3);
        chk(ctl.read_sel_n, !inv);
    endtask : access
    task t_spaces();
        for (int s = 0; s < 3; s++) for (int w = 0; w < 2; w++)
            access(s, w[0], 16'h8001 << s, d0);
        wait_cyc = 4'h3;
        access(1, 1'b0, 16'hFFFF, d3);
        chk(d3 - d0, 16'h3);
        wait_cyc = 4'h8;
        access(1, 1'b0, 16'h1234, d3);
        wait_cyc = 4'h0;
        chk(d3 - d0, 16'h8);
    endtask : t_spaces
    task t_mode(input logic [15:0] v);
        mode_wdata_in = v;
        mode_we_in = 1'b1;
        @(negedge clk_in);
        mode_we_in = 1'b0;
        inv = v[15];
        chk(mode_reg, v);
        access(2, 1'b0, 16'h0F0F, d0);
        access(0, 1'b1, 16'hF0F0, d0);
    endtask : t_mode
    task t_float();
        out_disable_n_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk({addr_oe, dbus_oe, ctl_oe}, 3'h0);
        out_disable_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask : t_float
    task wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #40000;
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk(mode_reg, 16'h0000);
        t_spaces();
        t_mode(16'h8000);
        t_mode(16'h0000);
        t_float();
        wrap_up();
    end
endmodule : tb_ebsc_bus_ctrl
